//--- hdl/adr_qdiv.sv
`default_nettype none
module adr_qdiv
  import adr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic drive,
  output logic out_a_q,
  output logic out_b_q
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic out_d;

  // ----------------------------------------------------------------
  // divide by four, restartable for phase alignment
  // ----------------------------------------------------------------
  always_comb begin
    if (restart) begin
      cnt_d = ADR_DIV_ZERO;
    end else begin
      cnt_d = cnt_q + ADR_DIV_STEP;
    end
    out_d = drive && cnt_d[1];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= ADR_DIV_ZERO;
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_a_q <= out_d;
      out_b_q <= out_d;
    end
  end
endmodule : adr_qdiv
`default_nettype wire

//--- hdl/adr_regs.sv
// Functional notes
// - coarse code bits 15:4 sets clock delay
// - coarse and fine delays apply only when adjust enable set
// - fine code bits 15:10 adds binary delay
// - duty-cycle fix on by default, bit 2
// - phase select picks latch phase quadrant
// - follower mode aligns dividers to reference
// - reference outputs carry quarter clock when enabled, held low while output clock reset is active
// - output enable independent of follower mode
// - output clock reset ignored while disabled
//
// The implementer's own choice: the APB register port.
`default_nettype none
module adr_regs
  import adr_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  input wire logic REF_CLK_IN,
  input wire logic OUTPUT_CLOCK_RESET_INPUT,
  output logic [11:0] COARSE_DELAY_CODE,
  output logic [5:0] FINE_DELAY_CODE,
  output logic DUTY_CYCLE_FIX_ENABLE,
  output logic [8:0] REF_CLOCK_DELAY,
  output logic [1:0] PHASE_SELECT,
  output logic [3:0] LATCH_PHASE,
  output logic FOLLOWER_MODE_ENABLE,
  output logic REF_CLOCK_OUT_A,
  output logic REF_CLOCK_OUT_B,
  output logic OUTPUT_CLOCK_RESET
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [15:0] coarse_q;
  logic [15:0] coarse_d;
  logic [15:0] fine_q;
  logic [15:0] fine_d;
  logic [15:0] sync_q;
  logic [15:0] sync_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic setup;
  logic wr_en;
  logic hit_coarse;
  logic hit_fine;
  logic hit_sync;
  logic hit_rsvd;
  logic hit_status;
  logic hit_none;
  logic [15:0] wmask;
  logic [15:0] rd_word;
  logic [15:0] status_word;
  logic [11:0] coarse_raw;
  logic [5:0] fine_raw;
  logic [8:0] rcd_raw;
  logic adj_en;
  logic duty_q;
  logic duty_d;
  logic follow_q;
  logic follow_d;
  logic [1:0] phase_q;
  logic [1:0] phase_d;
  logic [3:0] latch_q;
  logic [3:0] latch_d;
  logic clkrst_q;
  logic clkrst_d;
  logic ref_in_q;
  logic ref_rise;
  logic qdiv_restart;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setup = PSEL && !PENABLE;
  assign wr_en = PSEL && PENABLE && PWRITE && pready_q;

  always_comb begin
    hit_coarse = 1'b0;
    hit_fine = 1'b0;
    hit_sync = 1'b0;
    hit_rsvd = 1'b0;
    hit_status = 1'b0;
    hit_none = 1'b0;
    if (PADDR == ADR_ADDR_COARSE) begin
      hit_coarse = 1'b1;
    end else if (PADDR == ADR_ADDR_FINE) begin
      hit_fine = 1'b1;
    end else if (PADDR == ADR_ADDR_SYNC) begin
      hit_sync = 1'b1;
    end else if (PADDR == ADR_ADDR_RSVD_F) begin
      hit_rsvd = 1'b1;
    end else if (PADDR == ADR_ADDR_STATUS) begin
      hit_status = 1'b1;
    end else begin
      hit_none = 1'b1;
    end
  end

  // byte lanes 0 and 1 cover the 16-bit registers
  for (genvar g = 0; g < ADR_LANES; g++) begin : g_lane
    assign wmask[g*ADR_BYTE_W +: ADR_BYTE_W] = {ADR_BYTE_W{PSTRB[g]}};
  end

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  always_comb begin
    coarse_d = coarse_q;
    fine_d = fine_q;
    sync_d = sync_q;
    if (wr_en && hit_coarse) begin
      coarse_d = (coarse_q & ~wmask) | (PWDATA[15:0] & wmask);
    end
    if (wr_en && hit_fine) begin
      fine_d = (fine_q & ~wmask) | (PWDATA[15:0] & wmask);
    end
    if (wr_en && hit_sync) begin
      sync_d = (sync_q & ~wmask) | (PWDATA[15:0] & wmask);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      coarse_q <= ADR_COARSE_RST;
      fine_q <= ADR_FINE_RST;
      sync_q <= ADR_SYNC_RST;
    end else begin
      coarse_q <= coarse_d;
      fine_q <= fine_d;
      sync_q <= sync_d;
    end
  end

  // ----------------------------------------------------------------
  // read path and bus answer
  // ----------------------------------------------------------------
  always_comb begin
    status_word = ADR_HALF_ZERO;
    status_word[ADR_STAT_SAT_BIT] = coarse_raw > ADR_COARSE_MAX;
    status_word[ADR_STAT_OUT_BIT] = REF_CLOCK_OUT_A;
    status_word[ADR_STAT_RST_BIT] = clkrst_q;
  end

  always_comb begin
    if (hit_coarse) begin
      rd_word = coarse_q;
    end else if (hit_fine) begin
      rd_word = fine_q;
    end else if (hit_sync) begin
      rd_word = sync_q;
    end else if (hit_rsvd) begin
      rd_word = ADR_RSVD_F_VAL;
    end else if (hit_status) begin
      rd_word = status_word;
    end else begin
      rd_word = ADR_HALF_ZERO;
    end
  end

  always_comb begin
    pready_d = setup;
    pslverr_d = setup && hit_none;
    if (setup && !PWRITE) begin
      prdata_d = {ADR_HALF_ZERO, rd_word};
    end else begin
      prdata_d = '0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA = prdata_q;

  // ----------------------------------------------------------------
  // delay codes
  // ----------------------------------------------------------------
  assign coarse_raw = coarse_q[ADR_COARSE_MSB:ADR_COARSE_LSB];
  assign fine_raw = fine_q[ADR_FINE_MSB:ADR_FINE_LSB];
  assign rcd_raw = sync_q[ADR_RCD_MSB:ADR_RCD_LSB];
  assign adj_en = coarse_q[ADR_ADJ_EN_BIT];

  adr_sat_code #(
    .W(ADR_COARSE_W),
    .MAX_CODE(ADR_COARSE_MAX)
  ) u_coarse (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .apply(adj_en),
    .code(coarse_raw),
    .code_q(COARSE_DELAY_CODE)
  );

  adr_sat_code #(
    .W(ADR_FINE_W),
    .MAX_CODE(ADR_FINE_MAX)
  ) u_fine (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .apply(adj_en),
    .code(fine_raw),
    .code_q(FINE_DELAY_CODE)
  );

  adr_sat_code #(
    .W(ADR_RCD_W),
    .MAX_CODE(ADR_RCD_MAX)
  ) u_rcd (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .apply(1'b1),
    .code(rcd_raw),
    .code_q(REF_CLOCK_DELAY)
  );

  // ----------------------------------------------------------------
  // clocking controls
  // ----------------------------------------------------------------
  assign ref_rise = REF_CLK_IN && !ref_in_q;

  always_comb begin
    duty_d = coarse_q[ADR_DCC_BIT];
    follow_d = sync_q[ADR_FOLLOW_BIT];
    phase_d = sync_q[ADR_PHASE_MSB:ADR_PHASE_LSB];
    clkrst_d = OUTPUT_CLOCK_RESET_INPUT && !sync_q[ADR_RSTDIS_BIT];
  end

  // one-hot latch quadrant: 0, 90, 180, 270 degrees
  for (genvar p = 0; p < ADR_PHASES; p++) begin : g_phase
    assign latch_d[p] = phase_d == 2'(p);
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      duty_q <= ADR_COARSE_RST[ADR_DCC_BIT];
      follow_q <= ADR_SYNC_RST[ADR_FOLLOW_BIT];
      phase_q <= ADR_SYNC_RST[ADR_PHASE_MSB:ADR_PHASE_LSB];
      latch_q <= 4'h1 << ADR_SYNC_RST[ADR_PHASE_MSB:ADR_PHASE_LSB];
      clkrst_q <= 1'b0;
      ref_in_q <= 1'b0;
    end else begin
      duty_q <= duty_d;
      follow_q <= follow_d;
      phase_q <= phase_d;
      latch_q <= latch_d;
      clkrst_q <= clkrst_d;
      ref_in_q <= REF_CLK_IN;
    end
  end

  assign DUTY_CYCLE_FIX_ENABLE = duty_q;
  assign FOLLOWER_MODE_ENABLE = follow_q;
  assign PHASE_SELECT = phase_q;
  assign LATCH_PHASE = latch_q;
  assign OUTPUT_CLOCK_RESET = clkrst_q;

  // follower realigns on each rising reference edge; an output clock reset also restarts
  assign qdiv_restart = (follow_q && ref_rise) || clkrst_q;

  // drive depends only on the disable bit, never on mode
  adr_qdiv u_qdiv (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .restart(qdiv_restart),
    .drive(!sync_q[ADR_OUTDIS_BIT]),
    .out_a_q(REF_CLOCK_OUT_A),
    .out_b_q(REF_CLOCK_OUT_B)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);

  sequence apb_setup_s;
    PSEL && !PENABLE;
  endsequence

  sequence apb_access_s;
    PSEL && PENABLE && PREADY;
  endsequence

  apb_ready_a: assert property (apb_setup_s |=> PREADY ##1 !PREADY)
    else $error("setup not answered in one cycle");

  apb_err_a: assert property (apb_setup_s and hit_none |=> PSLVERR)
    else $error("unmapped address without error");

  coarse_wr_a: assert property (
    apb_access_s and (PWRITE && hit_coarse && PSTRB[1:0] == 2'b11)
    |=> coarse_q == $past(PWDATA[15:0]))
    else $error("coarse register write lost");

  coarse_lin_a: assert property (
    adj_en && coarse_raw <= ADR_COARSE_MAX |=> COARSE_DELAY_CODE == $past(coarse_raw))
    else $error("coarse code not applied");

  coarse_sat_a: assert property (
    adj_en && coarse_raw > ADR_COARSE_MAX |=> COARSE_DELAY_CODE == ADR_COARSE_MAX)
    else $error("coarse code not saturated");

  adjust_off_a: assert property (
    !adj_en |=> COARSE_DELAY_CODE == '0 && FINE_DELAY_CODE == '0)
    else $error("delay applied while adjust is off");

  fine_code_a: assert property (
    adj_en |=> FINE_DELAY_CODE == $past(fine_raw))
    else $error("fine code not applied");

  duty_fix_a: assert property (
    wr_en && hit_coarse && PSTRB[0] && !PWDATA[ADR_DCC_BIT] ##1 1'b1 |=> !DUTY_CYCLE_FIX_ENABLE)
    else $error("duty fix not disabled");

  rcd_sat_a: assert property (
    1'b1 |=> REF_CLOCK_DELAY == (($past(rcd_raw) > ADR_RCD_MAX) ? ADR_RCD_MAX : $past(rcd_raw)))
    else $error("reference delay code wrong");

  phase_hot_a: assert property (
    LATCH_PHASE == (4'h1 << PHASE_SELECT))
    else $error("latch phase does not match select");

  follow_align_a: assert property (
    FOLLOWER_MODE_ENABLE && ref_rise |=> !REF_CLOCK_OUT_A ##1 !REF_CLOCK_OUT_A)
    else $error("divider not realigned to reference");

  refout_off_a: assert property (
    sync_q[ADR_OUTDIS_BIT] |=> !REF_CLOCK_OUT_A && !REF_CLOCK_OUT_B)
    else $error("reference outputs driven while disabled");

  refout_run_a: assert property (
    (!sync_q[ADR_OUTDIS_BIT] && !qdiv_restart)[*5] |-> REF_CLOCK_OUT_A != $past(REF_CLOCK_OUT_A, 2))
    else $error("reference output not at quarter rate");

  refout_pair_a: assert property (
    REF_CLOCK_OUT_A == REF_CLOCK_OUT_B)
    else $error("reference outputs differ");

  clkrst_gate_a: assert property (
    OUTPUT_CLOCK_RESET_INPUT |=> OUTPUT_CLOCK_RESET == !$past(sync_q[ADR_RSTDIS_BIT]))
    else $error("output clock reset gating wrong");

  reset_load_a: assert property (
    disable iff (1'b0) SYS_RST |=> coarse_q == ADR_COARSE_RST && fine_q == ADR_FINE_RST
      && sync_q == ADR_SYNC_RST && !PREADY)
    else $error("register default not loaded");
endmodule : adr_regs
`default_nettype wire

//--- hdl/adr_sat_code.sv
`default_nettype none
module adr_sat_code
  import adr_pkg::*;
#(
  parameter int unsigned W = 12,
  parameter logic [W-1:0] MAX_CODE = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic apply,
  input wire logic [W-1:0] code,
  output logic [W-1:0] code_q
);
  logic [W-1:0] code_d;

  // ----------------------------------------------------------------
  // applied code: zero when off, clamped at the top
  // ----------------------------------------------------------------
  always_comb begin
    if (!apply) begin
      code_d = '0;
    end else if (code > MAX_CODE) begin
      code_d = MAX_CODE;
    end else begin
      code_d = code;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      code_q <= '0;
    end else begin
      code_q <= code_d;
    end
  end
endmodule : adr_sat_code
`default_nettype wire

//--- inc/adr_pkg.sv
`default_nettype none
package adr_pkg;
  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADR_REG_W = 16;
  localparam int unsigned ADR_BYTE_W = 8;
  localparam int unsigned ADR_LANES = 2;
  localparam logic [15:0] ADR_HALF_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // register indices and byte addresses (address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADR_IDX_COARSE = 4'hc;
  localparam logic [3:0] ADR_IDX_FINE = 4'hd;
  localparam logic [3:0] ADR_IDX_SYNC = 4'he;
  localparam logic [3:0] ADR_IDX_RSVD_F = 4'hf;
  localparam logic [7:0] ADR_ADDR_COARSE = {2'b00, ADR_IDX_COARSE, 2'b00};
  localparam logic [7:0] ADR_ADDR_FINE = {2'b00, ADR_IDX_FINE, 2'b00};
  localparam logic [7:0] ADR_ADDR_SYNC = {2'b00, ADR_IDX_SYNC, 2'b00};
  localparam logic [7:0] ADR_ADDR_RSVD_F = {2'b00, ADR_IDX_RSVD_F, 2'b00};
  localparam logic [7:0] ADR_ADDR_STATUS = 8'h40;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] ADR_COARSE_RST = 16'h0004;
  localparam logic [15:0] ADR_FINE_RST = 16'h0000;
  localparam logic [15:0] ADR_SYNC_RST = 16'h0003;
  localparam logic [15:0] ADR_RSVD_F_VAL = 16'h0018;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned ADR_COARSE_MSB = 15;
  localparam int unsigned ADR_COARSE_LSB = 4;
  localparam int unsigned ADR_ADJ_EN_BIT = 3;
  localparam int unsigned ADR_DCC_BIT = 2;
  localparam int unsigned ADR_FINE_MSB = 15;
  localparam int unsigned ADR_FINE_LSB = 10;
  localparam int unsigned ADR_RCD_MSB = 15;
  localparam int unsigned ADR_RCD_LSB = 7;
  localparam int unsigned ADR_PHASE_MSB = 4;
  localparam int unsigned ADR_PHASE_LSB = 3;
  localparam int unsigned ADR_FOLLOW_BIT = 2;
  localparam int unsigned ADR_OUTDIS_BIT = 1;
  localparam int unsigned ADR_RSTDIS_BIT = 0;
  localparam int unsigned ADR_STAT_SAT_BIT = 0;
  localparam int unsigned ADR_STAT_OUT_BIT = 1;
  localparam int unsigned ADR_STAT_RST_BIT = 2;

  // ----------------------------------------------------------------
  // code limits and delay spans
  // ----------------------------------------------------------------
  localparam int unsigned ADR_COARSE_W = 12;
  localparam int unsigned ADR_FINE_W = 6;
  localparam int unsigned ADR_RCD_W = 9;
  localparam int unsigned ADR_PHASES = 4;
  localparam logic [11:0] ADR_COARSE_MAX = 12'h097f;
  localparam logic [5:0] ADR_FINE_MAX = 6'h3f;
  localparam logic [8:0] ADR_RCD_MAX = 9'h13f;
  localparam int unsigned ADR_COARSE_SPAN_PS = 825;
  localparam int unsigned ADR_FINE_SPAN_FS = 2300;
  localparam int unsigned ADR_RCD_SPAN_PS = 1000;

  // ----------------------------------------------------------------
  // quarter-rate divider
  // ----------------------------------------------------------------
  localparam logic [1:0] ADR_DIV_ZERO = 2'b00;
  localparam logic [1:0] ADR_DIV_STEP = 2'b01;
endpackage : adr_pkg
`default_nettype wire

//--- test/adr_host_model.sv
`default_nettype none
module adr_host_model
  import adr_pkg::*;
(
  input wire logic clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end

  // ----------------------------------------------------------------
  // one bus transfer
  // ----------------------------------------------------------------
  // released address and data lines are inverted so stale values never pass as valid
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer

  // reserved fields always carry their defaults
  task automatic cfg_write(input logic [7:0] a, input logic [15:0] v);
    logic [31:0] rd;
    logic err;
    logic [15:0] m;
    m = (a == ADR_ADDR_COARSE) ? 16'hfffc : (a == ADR_ADDR_FINE) ? 16'hfc00 :
        (a == ADR_ADDR_SYNC) ? 16'hff9f : 16'hffff;
    xfer(1'b1, a, {16'h0000, v & m}, 4'h3, rd, err);
  endtask : cfg_write
endmodule : adr_host_model
`default_nettype wire

//--- test/aperture_delay_sync_regs_tb.sv
`default_nettype none
module aperture_delay_sync_regs_tb
  import adr_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, rst, psel, penable, pwrite, pready, pslverr, ref_in, ocr_in;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [11:0] coarse;
  logic [5:0] fine;
  logic duty, follow, out_a, out_b, ocr_out;
  logic [8:0] rcd;
  logic [1:0] phase;
  logic [3:0] latch;
  logic [15:0] sh_c, sh_f, sh_s;
  logic [31:0] rs;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;

  adr_host_model host (.clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb));

  adr_regs DUT (.CLK_SYS(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .REF_CLK_IN(ref_in),
    .OUTPUT_CLOCK_RESET_INPUT(ocr_in), .COARSE_DELAY_CODE(coarse), .FINE_DELAY_CODE(fine),
    .DUTY_CYCLE_FIX_ENABLE(duty), .REF_CLOCK_DELAY(rcd), .PHASE_SELECT(phase),
    .LATCH_PHASE(latch), .FOLLOWER_MODE_ENABLE(follow), .REF_CLOCK_OUT_A(out_a),
    .REF_CLOCK_OUT_B(out_b), .OUTPUT_CLOCK_RESET(ocr_out));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  function automatic logic [11:0] exp_coarse(input logic [15:0] c);
    if (c[3] !== 1'b1) return 12'h000;
    return (c[15:4] > 12'h097f) ? 12'h097f : c[15:4];
  endfunction : exp_coarse

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] rd;
    logic err;
    host.xfer(1'b0, a, 32'h0000_0000, 4'h0, rd, err);
    check(rd, e);
    check(err, ee);
  endtask : rd_chk

  task automatic check_all();
    repeat (2) @(posedge clk);
    check(coarse, exp_coarse(sh_c));
    check(fine, sh_c[3] ? sh_f[15:10] : 6'h00);
    check(duty, sh_c[2]);
    check(rcd, (sh_s[15:7] > 9'h13f) ? 9'h13f : sh_s[15:7]);
    check(phase, sh_s[4:3]);
    check(latch, 4'h1 << sh_s[4:3]);
    check(follow, sh_s[2]);
    rd_chk(ADR_ADDR_COARSE, {16'h0000, sh_c}, 1'b0);
    rd_chk(ADR_ADDR_FINE, {16'h0000, sh_f}, 1'b0);
    rd_chk(ADR_ADDR_SYNC, {16'h0000, sh_s}, 1'b0);
  endtask : check_all

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    if (a == ADR_ADDR_COARSE) sh_c = v & 16'hfffc;
    if (a == ADR_ADDR_FINE) sh_f = v & 16'hfc00;
    if (a == ADR_ADDR_SYNC) sh_s = v & 16'hff9f;
    host.cfg_write(a, v);
    check_all();
  endtask : wr

  // samples both reference outputs; q stays 1 while they match at quarter rate
  task automatic run_outs(input int n, input bit pulse, output int h, output bit q);
    logic s [32];
    h = 0;
    q = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      ref_in <= pulse && (i % 3 == 0) && (i + 1 < n);
      s[i] = out_a;
      if (out_b !== s[i]) q = 1'b0;
      if (s[i] === 1'b1) h++;
    end
    for (int i = 0; i + 4 < n; i++) begin
      if (s[i] !== s[i+4] || s[i] === s[i+2]) q = 1'b0;
    end
  endtask : run_outs

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r, rd;
    logic err;
    int h;
    bit q;
    logic [11:0] corner [6] = '{12'h000, 12'h001, 12'h97e, 12'h97f, 12'h980, 12'hfff};
    logic [8:0] rcorner [4] = '{9'h13e, 9'h13f, 9'h140, 9'h1ff};
    rst = 1'b1;
    ref_in = 1'b0;
    ocr_in = 1'b0;
    rs = 32'h0001_3208;
    sh_c = 16'h0004;
    sh_f = 16'h0000;
    sh_s = 16'h0003;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    check_all();
    check(out_a, 1'b0);
    rd_chk(ADR_ADDR_RSVD_F, 32'h0000_0018, 1'b0);
    foreach (corner[i]) wr(ADR_ADDR_COARSE, {corner[i], 4'b1100});
    wr(ADR_ADDR_FINE, 16'hfc00);
    wr(ADR_ADDR_COARSE, {12'h97f, 4'b0000});
    for (int i = 0; i < 4; i++) wr(ADR_ADDR_SYNC, {rcorner[i], 2'b00, 2'(i), 3'b011});
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      wr(ADR_ADDR_COARSE, r[15:0]);
      r = rnd();
      wr(ADR_ADDR_FINE, r[15:0]);
      r = rnd();
      wr(ADR_ADDR_SYNC, r[15:0]);
    end
    // refused and partial accesses
    host.xfer(1'b1, ADR_ADDR_RSVD_F, 32'h0000_ffff, 4'h3, rd, err);
    check(err, 1'b0);
    rd_chk(ADR_ADDR_RSVD_F, 32'h0000_0018, 1'b0);
    host.xfer(1'b1, 8'h44, 32'h0000_ffff, 4'h3, rd, err);
    check(err, 1'b1);
    host.xfer(1'b1, 8'h31, 32'h0000_fff0, 4'h3, rd, err);
    check(err, 1'b1);
    rd_chk(8'h44, 32'h0000_0000, 1'b1);
    host.xfer(1'b1, ADR_ADDR_COARSE, 32'h0000_abc8, 4'h1, rd, err);
    sh_c = {sh_c[15:8], 8'hc8};
    check_all();
    // reference clock outputs
    wr(ADR_ADDR_SYNC, 16'h0001);
    run_outs(16, 1'b0, h, q);
    check(h, 8);
    check(q, 1'b1);
    run_outs(16, 1'b1, h, q);
    check(q, 1'b1);
    wr(ADR_ADDR_SYNC, 16'h0005);
    run_outs(16, 1'b0, h, q);
    check(q, 1'b1);
    run_outs(12, 1'b1, h, q);
    run_outs(12, 1'b1, h, q);
    check(h, 4);
    wr(ADR_ADDR_SYNC, 16'h0007);
    run_outs(8, 1'b0, h, q);
    check(h, 0);
    // output clock reset gating
    wr(ADR_ADDR_SYNC, 16'h0003);
    ocr_in <= 1'b1;
    repeat (3) @(posedge clk);
    check(ocr_out, 1'b0);
    wr(ADR_ADDR_SYNC, 16'h0000);
    check(ocr_out, 1'b1);
    rd_chk(ADR_ADDR_STATUS, {29'h0000_0000, 1'b1, 1'b0, sh_c[15:4] > 12'h097f}, 1'b0);
    run_outs(8, 1'b0, h, q);
    check(h, 0);
    ocr_in <= 1'b0;
    repeat (3) @(posedge clk);
    check(ocr_out, 1'b0);
    tally_and_finish();
  end
endmodule : aperture_delay_sync_regs_tb
`default_nettype wire
